// File: src/conv_ctrl_defs.svh
`ifndef CONV_CTRL_DEFS_SVH
`define CONV_CTRL_DEFS_SVH

// Register byte offsets
`define OFF_SC1      12'h000
`define OFF_SC2      12'h004
`define OFF_RESH     12'h008
`define OFF_RESL     12'h00C
`define OFF_CMPH     12'h010
`define OFF_CMPL     12'h014
`define OFF_CFG      12'h018
`define OFF_PWR      12'h01C

// Status and control one fields
`define SC1_DONE     7
`define SC1_IEN      6
`define SC1_CONT     5
`define SC1_CH_HI    4
`define SC1_CH_LO    0
`define SC1_RESET    8'h1F

// Status and control two fields
`define SC2_ACT      7
`define SC2_TRG      6
`define SC2_CMPEN    5
`define SC2_CMPGE    4

// Configuration fields
`define CFG_MODE10   0
`define CFG_CLK_HI   2
`define CFG_CLK_LO   1

// Power register fields
`define PWR_RUN      0
`define PWR_LOW_VOLTAGE_DETECT_STOP_ENABLE    1

// Channel codes
`define CH_LAST_IN   5'h1B
`define CH_RESERVED  5'h1C
`define CH_HIGH_REFERENCE     5'h1D
`define CH_LOW_REFERENCE     5'h1E
`define CH_OFF       5'h1F

// Tick count at which a conversion ends; it lasts one conversion clock tick more than this
`define CONV_TICKS   5'h0E

`endif

// File: src/conv_ctrl_pkg.sv
package conv_ctrl_pkg;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_CONV = 2'b01,
        ST_DONE = 2'b11
    } conv_state_t;

    typedef struct packed {
        logic        cmp_en;
        logic        cmp_ge;
        logic        mode10;
        logic [9:0]  cmp_val;
    } cmp_cfg_t;

endpackage

// File: src/conv_compare.sv
`timescale 1ns/100ps
`include "conv_ctrl_defs.svh"

// Decides whether a finished result is kept and flagged
module conv_compare
    import conv_ctrl_pkg::*;
(
    // Result and settings
    input  wire logic [9:0] result,
    input  wire cmp_cfg_t   cfg,
    // Decision
    output logic            keep
);
    logic [9:0] r;
    logic [9:0] c;
    logic       ge;

    always_comb begin
        // In 8-bit mode the upper compare bits play no part
        r    = cfg.mode10 ? result : {2'h0, result[7:0]};
        c    = cfg.mode10 ? cfg.cmp_val : {2'h0, cfg.cmp_val[7:0]};
        ge   = (r >= c);
        keep = !cfg.cmp_en || (cfg.cmp_ge ? ge : !ge);
    end
endmodule

// File: src/conv_ctrl.sv
// Overview of operation
// - Hardware trigger accepted in run, wait, and in stop3 only with low-voltage detect kept on
// - Control-one write aborts; restarts conversion only with software trigger
// - Done flag set; compare gates it
// - Control-one write or low read clears flag
// - Interrupt raised when flag sets with enable
// - Single mode: one conversion per trigger
// - Continuous mode: back-to-back after trigger
// - Five-bit channel field selects input
// - All-ones channel powers converter off
// - All-ones stop runs no extra conversion
// - Single mode returns idle after conversion
// - Results right-justified, 10 or 8 bits
// - Automatic compare below or at-or-above value
// - Conversion clock from three sources; setting 10 falls back to the bus clock
// - Trigger select picks write or hardware
// - Direction bit picks at-or-above or below
// - High read locks results until low read, in 10-bit mode only
// - Active bit tracks conversion in progress
`timescale 1ns/100ps
`include "conv_ctrl_defs.svh"

module conv_ctrl
    import conv_ctrl_pkg::*;
(
    // APB slave
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Trigger and asynchronous conversion clock
    input  wire logic        hardware_trigger_input,
    input  wire logic        local_async_conv_clock,
    // Analog front end
    input  wire logic [9:0]  sar_result,
    output logic      [4:0]  analog_channel,
    output logic             analog_power_en,
    output logic             sample_start,
    // Interrupt
    output logic             done_irq
);

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    logic [7:0]  sc1_r;
    logic        trg_r;
    logic        cmp_en_r;
    logic        cmp_ge_r;
    logic [9:0]  cmp_r;
    logic        mode10_r;
    logic [1:0]  clk_sel_r;
    logic        pwr_run_r;
    logic        low_voltage_detect_stop_enable_r;
    logic [9:0]  res_r;
    logic        lock_r;
    logic        done_r;
    conv_state_t state_r;
    logic [4:0]  tick_cnt_r;
    logic        div_r;
    logic [2:0]  hwt_sync_r;
    logic [2:0]  ack_sync_r;

    logic        wr_en;
    logic        rd_en;
    logic        sc1_wr;
    logic        off_wr;
    logic        resl_rd;
    logic        resh_rd;
    logic        hwt_rise;
    logic        tick;
    logic        ch_off;
    logic        hw_ok;
    logic        start;
    logic        finish;
    logic        keep;
    logic [9:0]  res_fmt;
    logic [31:0] rd_mux;
    cmp_cfg_t    cfg;

    assign wr_en   = psel && penable && pwrite;
    assign rd_en   = psel && penable && !pwrite;
    assign sc1_wr  = wr_en && (paddr == `OFF_SC1);
    assign off_wr  = sc1_wr && (pwdata[`SC1_CH_HI:`SC1_CH_LO] == `CH_OFF);
    assign resl_rd = rd_en && (paddr == `OFF_RESL);
    assign resh_rd = rd_en && (paddr == `OFF_RESH);
    assign ch_off  = (sc1_r[`SC1_CH_HI:`SC1_CH_LO] == `CH_OFF);

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hwt_sync_r <= 3'h0;
            ack_sync_r <= 3'h0;
        end else begin
            hwt_sync_r <= {hwt_sync_r[1:0], hardware_trigger_input};
            ack_sync_r <= {ack_sync_r[1:0], local_async_conv_clock};
        end
    end

    assign hwt_rise = hwt_sync_r[1] && !hwt_sync_r[2];

    // In stop3 the trigger counts only with low-voltage detect kept on
    assign hw_ok = pwr_run_r || low_voltage_detect_stop_enable_r;

    // ----------------------------------------------------------------
    // Conversion clock select
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_r <= 1'b0;
        end else begin
            div_r <= !div_r;
        end
    end

    // Async source is seen as its rising edge, so it must be slow
    always_comb begin
        case (clk_sel_r)
            2'b00:   tick = 1'b1;
            2'b01:   tick = div_r;
            2'b11:   tick = ack_sync_r[1] && !ack_sync_r[2];
            default: tick = 1'b1;
        endcase
    end

    // ----------------------------------------------------------------
    // Conversion sequencer
    // ----------------------------------------------------------------
    // A write with the off code starts nothing and aborts what runs
    assign start = !ch_off && state_r == ST_IDLE &&
                   (trg_r ? (hwt_rise && hw_ok) : 1'b0);
    assign finish = (state_r == ST_CONV) && tick &&
                    (tick_cnt_r == `CONV_TICKS);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r    <= ST_IDLE;
            tick_cnt_r <= 5'h00;
        end else if (sc1_wr) begin
            tick_cnt_r <= 5'h00;
            // Software trigger restarts here; hardware waits for the pin
            if (off_wr) begin
                state_r <= ST_IDLE;
            end else if (!trg_r) begin
                state_r <= ST_CONV;
            end else begin
                state_r <= ST_IDLE;
            end
        end else begin
            case (state_r)
                ST_IDLE: begin
                    if (start) begin
                        state_r    <= ST_CONV;
                        tick_cnt_r <= 5'h00;
                    end
                end
                ST_CONV: begin
                    if (tick) begin
                        tick_cnt_r <= tick_cnt_r + 5'h01;
                    end
                    if (finish) begin
                        state_r <= ST_DONE;
                    end
                end
                ST_DONE: begin
                    tick_cnt_r <= 5'h00;
                    if (sc1_r[`SC1_CONT] && !ch_off) begin
                        state_r <= ST_CONV;
                    end else begin
                        state_r <= ST_IDLE;
                    end
                end
                default: state_r <= ST_IDLE;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Result and compare
    // ----------------------------------------------------------------
    assign cfg = '{cmp_en: cmp_en_r, cmp_ge: cmp_ge_r,
                   mode10: mode10_r, cmp_val: cmp_r};

    // 8-bit mode keeps the top eight bits, right-justified
    assign res_fmt = mode10_r ? sar_result : {2'h0, sar_result[9:2]};

    conv_compare u_cmp (
        .result (res_fmt),
        .cfg    (cfg),
        .keep   (keep)
    );

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            res_r <= 10'h000;
        end else if (finish && keep && !(lock_r && mode10_r)) begin
            res_r <= res_fmt;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lock_r <= 1'b0;
        end else if (resl_rd || !mode10_r) begin
            lock_r <= 1'b0;
        end else if (resh_rd) begin
            lock_r <= 1'b1;
        end
    end

    // Set wins over a clearing access in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            done_r <= 1'b0;
        end else if (finish && keep) begin
            done_r <= 1'b1;
        end else if (sc1_wr || resl_rd) begin
            done_r <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Software registers
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sc1_r     <= `SC1_RESET;
            trg_r     <= 1'b0;
            cmp_en_r  <= 1'b0;
            cmp_ge_r  <= 1'b0;
            cmp_r     <= 10'h000;
            mode10_r  <= 1'b0;
            clk_sel_r <= 2'h0;
            pwr_run_r <= 1'b1;
            low_voltage_detect_stop_enable_r   <= 1'b0;
        end else if (wr_en) begin
            case (paddr)
                `OFF_SC1:  sc1_r <= {1'b0, pwdata[6:0]};
                `OFF_SC2: begin
                    trg_r    <= pwdata[`SC2_TRG];
                    cmp_en_r <= pwdata[`SC2_CMPEN];
                    cmp_ge_r <= pwdata[`SC2_CMPGE];
                end
                `OFF_CMPH: cmp_r[9:8] <= pwdata[1:0];
                `OFF_CMPL: cmp_r[7:0] <= pwdata[7:0];
                `OFF_CFG: begin
                    mode10_r  <= pwdata[`CFG_MODE10];
                    clk_sel_r <= pwdata[`CFG_CLK_HI:`CFG_CLK_LO];
                end
                `OFF_PWR: begin
                    pwr_run_r <= pwdata[`PWR_RUN];
                    low_voltage_detect_stop_enable_r   <= pwdata[`PWR_LOW_VOLTAGE_DETECT_STOP_ENABLE];
                end
                default: ;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // APB read path
    // ----------------------------------------------------------------
    always_comb begin
        rd_mux = 32'h0000_0000;
        case (paddr)
            `OFF_SC1:  rd_mux = {24'h0, done_r, sc1_r[6:0]};
            `OFF_SC2:  rd_mux = {24'h0, (state_r == ST_CONV), trg_r,
                                 cmp_en_r, cmp_ge_r, 4'h0};
            `OFF_RESH: rd_mux = {30'h0, res_r[9:8]};
            `OFF_RESL: rd_mux = {24'h0, res_r[7:0]};
            `OFF_CMPH: rd_mux = {30'h0, cmp_r[9:8]};
            `OFF_CMPL: rd_mux = {24'h0, cmp_r[7:0]};
            `OFF_CFG:  rd_mux = {29'h0, clk_sel_r, mode10_r};
            `OFF_PWR:  rd_mux = {30'h0, low_voltage_detect_stop_enable_r, pwr_run_r};
            default:   rd_mux = 32'h0000_0000;
        endcase
    end

    // Zero-wait slave: pready is registered, low in reset and high from the first clock after it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= 1'b1;
            pslverr <= 1'b0;
            if (psel && !penable && !pwrite) begin
                prdata <= rd_mux;
            end
        end
    end

    // ----------------------------------------------------------------
    // Analog controls and interrupt
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            analog_channel  <= `CH_OFF;
            analog_power_en <= 1'b0;
            sample_start    <= 1'b0;
            done_irq        <= 1'b0;
        end else begin
            analog_channel  <= sc1_r[`SC1_CH_HI:`SC1_CH_LO];
            analog_power_en <= !ch_off && (state_r != ST_IDLE);
            sample_start    <= sc1_wr ? (!trg_r && !off_wr) :
                               (start || (state_r == ST_DONE &&
                                sc1_r[`SC1_CONT] && !ch_off));
            done_irq        <= done_r && sc1_r[`SC1_IEN];
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    a_irq_level: assert property (@(posedge pclk)
        disable iff (!presetn) done_irq == $past(done_r && sc1_r[`SC1_IEN]))
        else $error("irq not following flag and enable");
    a_done_clear: assert property (@(posedge pclk)
        disable iff (!presetn) (sc1_wr && !(finish && keep)) |=> !done_r)
        else $error("flag not cleared by write");
    a_done_set: assert property (@(posedge pclk)
        disable iff (!presetn) (finish && keep) |=> done_r)
        else $error("flag not set on kept result");
    a_off_abort: assert property (@(posedge pclk)
        disable iff (!presetn) off_wr |=> (state_r == ST_IDLE) [*2])
        else $error("off code did not stop converter");
    a_sw_restart: assert property (@(posedge pclk)
        disable iff (!presetn) (sc1_wr && !trg_r && !off_wr) |=>
        state_r == ST_CONV && tick_cnt_r == 5'h00)
        else $error("write did not restart conversion");
    a_single_idle: assert property (@(posedge pclk)
        disable iff (!presetn)
        (state_r == ST_DONE && !sc1_r[`SC1_CONT] && !sc1_wr) |=>
        state_r == ST_IDLE)
        else $error("single mode did not return idle");
    a_cont_again: assert property (@(posedge pclk)
        disable iff (!presetn)
        (state_r == ST_DONE && sc1_r[`SC1_CONT] && !ch_off && !sc1_wr)
        |=> state_r == ST_CONV)
        else $error("continuous mode did not rerun");
    a_lock_hold: assert property (@(posedge pclk)
        disable iff (!presetn) (lock_r && mode10_r) |=> $stable(res_r))
        else $error("result changed while locked");
    a_hw_start: assert property (@(posedge pclk)
        disable iff (!presetn)
        (state_r == ST_IDLE && trg_r && hwt_rise && hw_ok && !ch_off
         && !sc1_wr) |=> state_r == ST_CONV)
        else $error("hardware trigger ignored");
    a_start_conv: assert property (@(posedge pclk)
        disable iff (!presetn)
        sample_start |-> state_r == ST_CONV && tick_cnt_r == 5'h00)
        else $error("start pulse without fresh conversion");
endmodule

// File: tb/front_end_model.sv
`timescale 1ns/100ps

// Stand-in for the analog front end and the local conversion clock
module front_end_model (
    // From the block
    input  wire logic       analog_power_en,
    // Level chosen by the bench
    input  wire logic [9:0] level,
    // Towards the block
    output logic      [9:0] sar_result,
    output logic            local_async_conv_clock
);
    // Unpowered output is junk, so show the inverse rather than a held value
    assign sar_result = analog_power_en ? level : ~level;

    // Free running, unrelated in phase to the bus clock
    initial begin
        local_async_conv_clock = 1'b0;
        forever #170 local_async_conv_clock = ~local_async_conv_clock;
    end
endmodule

// File: tb/tb_sar_adc_conversion_control.sv
`timescale 1ns/100ps
`include "conv_ctrl_defs.svh"

module tb_sar_adc_conversion_control;
    logic        pclk, presetn, psel, penable, pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic        pready, pslverr, hw_trig, async_clk;
    logic [9:0]  sar_result, level;
    logic [4:0]  analog_channel;
    logic        analog_power_en, sample_start, done_irq;
    logic [15:0] lfsr;
    int          n_errors, n_compared, s0;
    int          n_starts = 0;
    // Bandgap before sensor channel, then the reference codes
    logic [4:0]  chans [5] = '{5'h1B, 5'h1A, 5'h00, 5'h1D, 5'h1E};

    conv_ctrl conv_ctrl_inst (
        .pclk                   (pclk),
        .presetn                (presetn),
        .psel                   (psel),
        .penable                (penable),
        .pwrite                 (pwrite),
        .paddr                  (paddr),
        .pwdata                 (pwdata),
        .prdata                 (prdata),
        .pready                 (pready),
        .pslverr                (pslverr),
        .hardware_trigger_input (hw_trig),
        .local_async_conv_clock (async_clk),
        .sar_result             (sar_result),
        .analog_channel         (analog_channel),
        .analog_power_en        (analog_power_en),
        .sample_start           (sample_start),
        .done_irq               (done_irq)
    );

    front_end_model front_end_model_inst (
        .analog_power_en        (analog_power_en),
        .level                  (level),
        .sar_result             (sar_result),
        .local_async_conv_clock (async_clk)
    );

    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end

    // Start pulses are counted mid-cycle, where they have settled
    always @(negedge pclk) begin
        if (sample_start === 1'b1) begin
            n_starts++;
        end
    end

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic [15:0] step(logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    function automatic logic keep(logic [9:0] v, logic ge);
        return ge ? (v >= 10'h200) : (v < 10'h200);
    endfunction

    task automatic stop_test();
        $display("compared %0d errors %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] exp,
                         input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d, output logic [31:0] q);
        int k;
        k = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 16);
        if (pready !== 1'b1) begin
            n_errors++;
            $display("MISMATCH pready expected 1 seen %b", pready);
            stop_test();
        end
        q = prdata;
        check("pslverr", 32'h0, 32'(pslverr));
        psel <= 1'b0;
        penable <= 1'b0;
        // Idle cycle so back-to-back calls never drive twice in a step
        @(posedge pclk);
    endtask

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        logic [31:0] q;
        apb(1'b1, a, {24'h0, d}, q);
    endtask

    task automatic rd(input logic [11:0] a, output logic [31:0] q);
        apb(1'b0, a, 32'h0, q);
    endtask

    task automatic wait_done(output logic seen);
        logic [31:0] q;
        seen = 1'b0;
        for (int i = 0; i < 40 && !seen; i++) begin
            rd(`OFF_SC1, q);
            seen = q[`SC1_DONE];
        end
    endtask

    task automatic conv(input logic [7:0] sc1, output logic seen);
        wr(`OFF_SC1, sc1);
        wait_done(seen);
    endtask

    task automatic pulse();
        hw_trig <= 1'b1;
        repeat (4) @(posedge pclk);
        hw_trig <= 1'b0;
    endtask

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        logic [31:0] q;
        logic        seen;
        logic [9:0]  v;
        logic [4:0]  ch;
        logic        ge;
        {psel, penable, pwrite, hw_trig} = 4'h0;
        paddr = 12'h000;
        pwdata = 32'h0;
        level = 10'h000;
        lfsr = 16'h0010;
        n_errors = 0;
        n_compared = 0;
        presetn = 1'b0;
        repeat (3) @(posedge pclk);
        check("channel in reset", 32'h1F, 32'(analog_channel));
        check("power in reset", 32'h0, 32'(analog_power_en));
        presetn <= 1'b1;
        @(posedge pclk);
        rd(`OFF_SC1, q);
        check("control one reset", 32'h1F, q);
        rd(12'h0FC, q);
        check("unmapped read", 32'h0, q);
        // Every clock source, both resolutions, table then random channels
        for (int i = 0; i < 8; i++) begin
            lfsr = step(lfsr);
            v = lfsr[9:0];
            ch = (i < 5) ? chans[i] : lfsr[14:10] % 5'h1F;
            wr(`OFF_CFG, {5'h0, i[1:0], i[2]});
            level <= v;
            s0 = n_starts;
            conv({3'b010, ch}, seen);
            check("done flag", 32'h1, 32'(seen));
            check("starts", 32'h1, 32'(n_starts - s0));
            check("channel", 32'(ch), 32'(analog_channel));
            check("irq level", 32'h1, 32'(done_irq));
            check("power after", 32'h0, 32'(analog_power_en));
            rd(`OFF_SC2, q);
            check("active bit", 32'h0, 32'(q[`SC2_ACT]));
            rd(`OFF_RESH, q);
            check("result high", i[2] ? 32'(v[9:8]) : 32'h0, q);
            rd(`OFF_RESL, q);
            check("result low", 32'(i[2] ? v[7:0] : v[9:2]), q);
            rd(`OFF_SC1, q);
            check("flag cleared", 32'h0, 32'(q[`SC1_DONE]));
            check("irq cleared", 32'h0, 32'(done_irq));
        end
        // Restart in mid conversion, then a single run only
        wr(`OFF_CFG, 8'h01);
        wr(`OFF_SC1, 8'h05);
        wr(`OFF_SC1, 8'h06);
        rd(`OFF_SC2, q);
        check("active in run", 32'h1, 32'(q[`SC2_ACT]));
        wait_done(seen);
        check("restart done", 32'h1, 32'(seen));
        check("restart channel", 32'h6, 32'(analog_channel));
        rd(`OFF_RESL, q);
        wait_done(seen);
        check("single only", 32'h0, 32'(seen));
        // Continuous runs stopped by the all-ones channel
        conv(8'h23, seen);
        check("first run", 32'h1, 32'(seen));
        rd(`OFF_RESL, q);
        wait_done(seen);
        check("next run", 32'h1, 32'(seen));
        wr(`OFF_SC1, 8'h3F);
        s0 = n_starts;
        rd(`OFF_SC1, q);
        check("flag on stop", 32'h0, 32'(q[`SC1_DONE]));
        check("powered off", 32'h0, 32'(analog_power_en));
        rd(`OFF_SC2, q);
        check("aborted", 32'h0, 32'(q[`SC2_ACT]));
        wait_done(seen);
        check("no extra run", 32'h0, 32'(seen));
        check("no extra start", 32'h0, 32'(n_starts - s0));
        // Compare against 0x200 at the boundary and at random
        wr(`OFF_CMPH, 8'h02);
        wr(`OFF_CMPL, 8'h00);
        for (int j = 0; j < 6; j++) begin
            lfsr = step(lfsr);
            ge = j[0];
            v = (j < 2) ? 10'h200 : (j < 4) ? 10'h1FF : lfsr[9:0];
            wr(`OFF_SC2, {2'b00, 1'b1, ge, 4'h0});
            level <= v;
            conv(8'h04, seen);
            check("compare flag", 32'(keep(v, ge)), 32'(seen));
            rd(`OFF_RESL, q);
        end
        // Hardware trigger, refused in deep stop, taken once allowed
        wr(`OFF_SC2, 8'h40);
        wr(`OFF_PWR, 8'h00);
        wr(`OFF_SC1, 8'h02);
        pulse();
        wait_done(seen);
        check("trigger in stop", 32'h0, 32'(seen));
        wr(`OFF_PWR, 8'h02);
        pulse();
        wait_done(seen);
        check("trigger taken", 32'h1, 32'(seen));
        rd(`OFF_RESL, q);
        wait_done(seen);
        check("one per trigger", 32'h0, 32'(seen));
        // High read holds the old result until the low read
        wr(`OFF_SC2, 8'h00);
        level <= 10'h155;
        conv(8'h01, seen);
        rd(`OFF_RESH, q);
        level <= 10'h2AA;
        conv(8'h01, seen);
        rd(`OFF_RESL, q);
        check("locked result", 32'h55, q);
        stop_test();
    end
endmodule
